// ==== hw/io_cell_defines.vh ====
// Constants for the io_cell output path: register map, field positions, reset values.
// Assumes inclusion by the single design file under hw/, after no other header.
`ifndef IO_CELL_DEFINES_VH
`define IO_CELL_DEFINES_VH

// ****************************************************************
// Register word offsets (byte addresses)
// ****************************************************************
`define ADDR_CELL_CONFIG     8'h00
`define ADDR_CELL_STATUS     8'h04
`define ADDR_CELL_PULSE      8'h08

// ****************************************************************
// Configuration word fields
// ****************************************************************
`define CFG_OUT_INVERT       0
`define CFG_HIZ_INVERT       1
`define CFG_USE_FLOP         2
`define CFG_FAST_SLEW        3
`define CFG_FUNC_MODE        4
`define CFG_FUNC_OP_LO       5
`define CFG_FUNC_OP_HI       6
`define CFG_INV_FAST         7
`define CFG_INV_SECOND       8
`define CFG_INIT_SET         9
`define CFG_CLK_INVERT       10
`define CFG_GHIZ_INVERT      11
`define CFG_GHIZ_FROM_NODE   12
`define CFG_CE_CONNECTED     13
`define CFG_HIZ_CONNECTED    14
`define CFG_OPEN_DRAIN       15
`define CFG_WIDTH            16
`define CFG_RESET            16'h0000

// ****************************************************************
// Function generator operations
// ****************************************************************
`define FUNC_PASS            2'h0
`define FUNC_AND             2'h1
`define FUNC_OR              2'h2
`define FUNC_XOR             2'h3

// ****************************************************************
// Status word fields
// ****************************************************************
`define STS_PAD_OUT          0
`define STS_PAD_OE_N         1
`define STS_FAST_SLEW        2
`define STS_FLOP_Q           3
`define STS_SOFT_DONE        4
`define STS_GHIZ_FORCED      5
`define STS_WIDTH            6

// ****************************************************************
// Pulse word fields (write one to fire)
// ****************************************************************
`define PULSE_PRESET_CLEAR   0
`define PULSE_RESTART       1

`endif

// ==== hw/io_cell_output_path.v ====
// Output path of one programmable io_cell with a classic Wishbone slave for its
// configuration. Assumes all user signals except global_hiz_pin come from logic
// on clock; the pad itself is resolved outside from pad_out and pad_oe_n.
//
// Notes on behaviour
// RQ1: Output value, optionally inverted, goes straight or through the output flop.
// RQ2: High-impedance enable high floats the driver; low drives the selected value.
// RQ3: Output polarity and high-impedance polarity are configured independently.
// RQ4: Flop loads on active output clock edge with enable high, else holds.
// RQ5: Unconnected clock enable counts as high; flop loads every active edge.
// RQ6: Unconnected high-impedance enable counts as low; pad driven by default.
// RQ7: Open drain: data forced low, signal itself used as high-impedance enable.
// RQ8: Slew defaults to reduced; a per-cell fast option selects full speed.
// RQ9: First output activation after start-up is slew limited, then cell setting.
// RQ10: Global high-impedance floats outputs except during boundary-scan external test.
// RQ11: Global high-impedance comes from a pin, optionally inverted, or internal node.
// RQ12: Output multiplexer lets two internal signals share the pad in time.
// RQ13: Multiplexer may instead compute pass, AND, OR, XOR with optional inversions.
// RQ14: Critical operand enters on the fast-gate input, shortest path to function.
// RQ15: Preset/clear forces flop to its configured initial state at power-up and pulse.
// RQ16: Output flop clock invertible, giving rising- or falling-edge triggering.
// RQ17: Multiplexer select low picks first source, high picks second source.
// RQ18: Global forcing overrides cell enable and registered or direct selection.
`include "io_cell_defines.vh"

module io_cell_output_path (
    input  wire        clock,
    input  wire        rst_n,
    // Wishbone classic slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire [3:0]  wb_sel_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Internal user logic, same clock
    input  wire        first_source,
    input  wire        second_source,
    input  wire        fast_gate,
    input  wire        mux_select,
    input  wire        out_clock,
    input  wire        clock_enable,
    input  wire        hiz_enable,
    input  wire        global_hiz_node,
    input  wire        global_preset_clear,
    input  wire        extest_active,
    input  wire        config_done,
    // From a device pin, asynchronous
    input  wire        global_hiz_pin,
    // Pad side
    output reg         pad_out,
    output reg         pad_oe_n,
    output reg         pad_fast_slew
);

    // ****************************************************************
    // Decoding helpers
    // ****************************************************************
    function func_gen;
        input [1:0] op;
        input       a;
        input       b;
        begin
            case (op)
                `FUNC_PASS: func_gen = a;
                `FUNC_AND:  func_gen = a & b;
                `FUNC_OR:   func_gen = a | b;
                `FUNC_XOR:  func_gen = a ^ b;
                default:    func_gen = a;
            endcase
        end
    endfunction

    function hit;
        input [7:0] adr;
        input [7:0] target;
        begin
            hit = (adr == target);
        end
    endfunction

    // ****************************************************************
    // Register state
    // ****************************************************************
    reg [`CFG_WIDTH-1:0] cfg_reg;
    reg                  ghiz_meta_reg;
    reg                  ghiz_sync_reg;
    reg                  clk_prev_reg;
    reg                  flop_q_reg;
    reg                  init_pending_reg;
    reg                  soft_done_reg;
    reg                  activated_reg;
    reg                  pulse_pc_reg;
    // Declared early: the status read path uses it before its logic
    wire                 ghiz_forced;

    wire bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr   = bus_req & wb_we_i;

    // ****************************************************************
    // Wishbone slave: one wait state, unmapped reads zero, writes dropped
    // ****************************************************************
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= 32'h0000_0000;
            if (bus_req && !wb_we_i) begin
                if (hit(wb_adr_i, `ADDR_CELL_CONFIG)) begin
                    wb_dat_o <= {16'h0000, cfg_reg};
                end else if (hit(wb_adr_i, `ADDR_CELL_STATUS)) begin
                    wb_dat_o <= {26'h000_0000, ghiz_forced, soft_done_reg, flop_q_reg,
                                 pad_fast_slew, pad_oe_n, pad_out};
                end
            end
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg <= `CFG_RESET;
        end else if (bus_wr && hit(wb_adr_i, `ADDR_CELL_CONFIG)) begin
            if (wb_sel_i[0]) begin
                cfg_reg[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                cfg_reg[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    wire pulse_hit   = bus_wr & hit(wb_adr_i, `ADDR_CELL_PULSE) & wb_sel_i[0];
    wire sw_preset   = pulse_hit & wb_dat_i[`PULSE_PRESET_CLEAR];
    wire sw_restart  = pulse_hit & wb_dat_i[`PULSE_RESTART];

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pulse_pc_reg <= 1'b0;
        end else begin
            pulse_pc_reg <= sw_preset;
        end
    end

    // ****************************************************************
    // Global high-impedance source
    // ****************************************************************
    // Pin is asynchronous; only the second stage is used
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ghiz_meta_reg <= 1'b0;
            ghiz_sync_reg <= 1'b0;
        end else begin
            ghiz_meta_reg <= global_hiz_pin;
            ghiz_sync_reg <= ghiz_meta_reg;
        end
    end

    wire ghiz_raw = cfg_reg[`CFG_GHIZ_FROM_NODE] ? global_hiz_node : ghiz_sync_reg; // see RQ11
    wire ghiz_line = ghiz_raw ^ cfg_reg[`CFG_GHIZ_INVERT]; // see RQ11
    assign ghiz_forced = ghiz_line & ~extest_active; // see RQ10

    // ****************************************************************
    // Output multiplexer or two-input function
    // ****************************************************************
    // Critical operand uses fast_gate, never the slower routed source
    wire op_fast   = fast_gate ^ cfg_reg[`CFG_INV_FAST];        // see RQ14
    wire op_second = first_source ^ cfg_reg[`CFG_INV_SECOND];   // see RQ13
    wire mux_val   = mux_select ? second_source : first_source; // see RQ12, RQ17
    wire func_val  = func_gen(cfg_reg[`CFG_FUNC_OP_HI:`CFG_FUNC_OP_LO],
                              op_fast, op_second);              // see RQ13
    wire path_val  = cfg_reg[`CFG_FUNC_MODE] ? func_val : mux_val;
    wire out_val   = path_val ^ cfg_reg[`CFG_OUT_INVERT];       // see RQ1, RQ3

    // ****************************************************************
    // Output flop
    // ****************************************************************
    // Output clock is a logic signal; edges are detected on clock
    wire clk_now  = out_clock ^ cfg_reg[`CFG_CLK_INVERT];        // see RQ16
    wire clk_edge = clk_now & ~clk_prev_reg;
    wire ce_eff   = cfg_reg[`CFG_CE_CONNECTED] ? clock_enable : 1'b1; // see RQ5
    wire preset   = global_preset_clear | pulse_pc_reg | init_pending_reg;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            clk_prev_reg     <= 1'b0;
            flop_q_reg       <= 1'b0;
            init_pending_reg <= 1'b1;
        end else begin
            clk_prev_reg     <= clk_now;
            init_pending_reg <= 1'b0;
            if (preset) begin
                flop_q_reg <= cfg_reg[`CFG_INIT_SET]; // see RQ15
            end else if (clk_edge && ce_eff) begin
                flop_q_reg <= out_val;                // see RQ4
            end
        end
    end

    // ****************************************************************
    // Pad driver
    // ****************************************************************
    wire sel_val  = cfg_reg[`CFG_USE_FLOP] ? flop_q_reg : out_val; // see RQ1
    wire hiz_in   = cfg_reg[`CFG_HIZ_CONNECTED] ? hiz_enable : 1'b0; // see RQ6
    wire hiz_cell = hiz_in ^ cfg_reg[`CFG_HIZ_INVERT];             // see RQ3
    // Open drain: signal floats when high, drives zero when low
    wire od       = cfg_reg[`CFG_OPEN_DRAIN];
    wire drv_val  = od ? 1'b0 : sel_val;                           // see RQ7
    wire drv_hiz  = od ? sel_val : hiz_cell;                       // see RQ7
    wire float_n  = ~(ghiz_forced | drv_hiz);                      // see RQ2, RQ18

    // ****************************************************************
    // Soft start-up
    // ****************************************************************
    // Slew stays reduced until the first activation has been driven once
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            activated_reg <= 1'b0;
            soft_done_reg <= 1'b0;
        end else if (!config_done || sw_restart) begin
            activated_reg <= 1'b0;
            soft_done_reg <= 1'b0;
        end else begin
            if (float_n) begin
                activated_reg <= 1'b1;
            end
            if (activated_reg) begin
                soft_done_reg <= 1'b1; // see RQ9
            end
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pad_out       <= 1'b0;
            pad_oe_n      <= 1'b1;
            pad_fast_slew <= 1'b0;
        end else begin
            pad_out       <= drv_val;
            pad_oe_n      <= ~(float_n & config_done);                       // see RQ2
            pad_fast_slew <= soft_done_reg & cfg_reg[`CFG_FAST_SLEW];       // see RQ8, RQ9
        end
    end

endmodule

// ==== dv/pad_model.sv ====
// Board-side model of the io_cell pad wire.
// Assumes pad_out and pad_oe_n are sampled on clock; no pull on the wire.
// ****************************************
// Pad wire
// ****************************************
module pad_model (
    input  wire logic clock,
    input  wire logic pad_out,
    input  wire logic pad_oe_n,
    output logic      pad_level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last_reg = 1'b0;
    always @(posedge clock) begin
        if (!pad_oe_n) begin
            last_reg <= pad_out;
        end
    end
    // Floating wire shows the inverse, so a stale value never passes
    assign pad_level = pad_oe_n ? ~last_reg : pad_out;
endmodule

// ==== dv/io_cell_chk.sv ====
// Port-timing checker for io_cell_output_path.
// Assumes a one-cycle bus answer and registered pad outputs.
// ****************************************
// Checker
// ****************************************
module io_cell_chk (
    input wire        clock,
    input wire        rst_n,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        config_done,
    input wire        pad_oe_n,
    input wire        pad_fast_slew
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack one cycle after request");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    unmapped_zero_a: assert property (wb_ack_o && wb_cyc_i && !wb_we_i
        && wb_adr_i >= 8'h08 |-> wb_dat_o == 32'h0000_0000)
        else $error("write-only or unmapped read not zero");
    float_unconf_a: assert property (!config_done |=> pad_oe_n)
        else $error("pad driven before start-up");
    soft_slow_a: assert property (!config_done |-> ##2 !pad_fast_slew)
        else $error("fast slew without soft start");
    fast_cause_a: assert property ($rose(pad_fast_slew) |->
        $past(config_done, 2) && $past(config_done, 3))
        else $error("fast slew rose too early");
    cover property (wb_ack_o && wb_we_i);
    cover property ($rose(pad_fast_slew));
    cover property ($fell(pad_oe_n));
endmodule

bind io_cell_output_path io_cell_chk io_cell_chk_i (.clock, .rst_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .config_done, .pad_oe_n, .pad_fast_slew);

// ==== dv/io_cell_output_path_bench.sv ====
// Self-checking bench for io_cell_output_path with a pad wire model.
// Assumes a one-cycle Wishbone answer and registered pad outputs.
// ****************************************
// Bench
// ****************************************
module io_cell_output_path_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = '0, rst_n = '0, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0;
    logic [7:0]  wb_adr_i = '0;
    logic [31:0] wb_dat_i = '0, wb_dat_o;
    logic [3:0]  wb_sel_i = '0;
    logic wb_ack_o, first_source = '0, second_source = '0, fast_gate = '0, mux_select = '0;
    logic out_clock = '0, clock_enable = '0, hiz_enable = '0, global_hiz_node = '0;
    logic global_preset_clear = '0, extest_active = '0, config_done = '0, global_hiz_pin = '0;
    logic pad_out, pad_oe_n, pad_fast_slew, pad_level;
    int   error_cnt = 0, cmp_count = 0, seed = 32'h0000_38b1;
    io_cell_output_path io_cell_output_path_i (.clock, .rst_n, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .first_source,
        .second_source, .fast_gate, .mux_select, .out_clock, .clock_enable, .hiz_enable,
        .global_hiz_node, .global_preset_clear, .extest_active, .config_done,
        .global_hiz_pin, .pad_out, .pad_oe_n, .pad_fast_slew);
    pad_model pad_model_i (.clock, .pad_out, .pad_oe_n, .pad_level);
    initial forever #50 clock = ~clock;
    task wrap_up;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e, input string n);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task w(input int k);
        repeat (k) @(posedge clock);
    endtask
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clock);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, 4'hf};
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n == 20) begin
            error_cnt++;
            wrap_up;
        end
        r = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clock);
    endtask
    task cfg(input logic [15:0] c);
        logic [31:0] r;
        wb(1'b1, 8'h00, {16'h0000, c}, r);
    endtask
    task oc(input logic v);
        out_clock <= v;
        w(4);
    endtask
    // Mux or two-input function, then output polarity
    function logic exp_v(input logic [15:0] c, input logic f, s, k, m);
        logic a, b, r;
        a = k ^ c[7];
        b = f ^ c[8];
        case (c[6:5])
            2'h0: r = a;
            2'h1: r = a & b;
            2'h2: r = a | b;
            default: r = a ^ b;
        endcase
        return (c[4] ? r : (m ? s : f)) ^ c[0];
    endfunction
    initial begin
        #500_000;
        error_cnt++;
        wrap_up;
    end
    initial begin
        logic [31:0] r, rnd;
        logic [15:0] c;
        logic v, fl;
        w(4);
        rst_n <= 1'b1;
        wb(1'b0, 8'h00, '0, r);
        chk(r, 32'h0000_0000, "config reset");
        wb(1'b0, 8'h0c, '0, r);
        chk(r, 32'h0000_0000, "unmapped read");
        cfg(16'h0008);
        w(2);
        chk(pad_oe_n, 1'b1, "unconfigured float");
        {first_source, config_done} <= 2'b11;
        w(2);
        chk(pad_fast_slew, 1'b0, "first activation slew");
        w(6);
        chk(pad_fast_slew, 1'b1, "cell fast slew");
        cfg(16'h0000);
        w(3);
        chk(pad_fast_slew, 1'b0, "reduced slew");
        repeat (32) begin
            c = ($random(seed) & 16'hc1fb) | 16'h1000;
            if (c[15]) c[14] = 1'b0;
            c[1] = c[1] & c[14];
            rnd = $random(seed);
            cfg(c);
            {extest_active, global_hiz_node, hiz_enable, mux_select, fast_gate, second_source,
                first_source} <= rnd[6:0];
            w(3);
            v = exp_v(c, first_source, second_source, fast_gate, mux_select);
            fl = (c[14] & (hiz_enable ^ c[1])) | (global_hiz_node & !extest_active);
            if (c[15]) begin
                chk(pad_out, 1'b0, "drain data");
                chk(pad_oe_n, v | fl, "drain enable");
            end else begin
                chk(pad_oe_n, fl, "cell enable");
                if (!fl) chk(pad_level, v, "pad value");
            end
        end
        {extest_active, global_hiz_node, hiz_enable, mux_select} <= 4'b0010;
        cfg(16'h0000);
        global_hiz_pin <= 1'b1;
        w(6);
        chk(pad_oe_n, 1'b1, "global pin float");
        extest_active <= 1'b1;
        w(4);
        chk(pad_oe_n, 1'b0, "extest drive");
        {extest_active, global_hiz_pin} <= 2'b00;
        cfg(16'h0800);
        w(6);
        chk(pad_oe_n, 1'b1, "inverted global pin");
        cfg(16'h2204);
        {first_source, global_preset_clear} <= 2'b01;
        @(posedge clock);
        global_preset_clear <= 1'b0;
        w(4);
        chk(pad_level, 1'b1, "preset state");
        oc(1'b1);
        chk(pad_level, 1'b1, "hold enable low");
        clock_enable <= 1'b1;
        oc(1'b0);
        oc(1'b1);
        chk(pad_level, 1'b0, "flop load");
        cfg(16'h0204);
        {first_source, clock_enable} <= 2'b10;
        oc(1'b0);
        oc(1'b1);
        chk(pad_level, 1'b1, "enable unconnected");
        cfg(16'h0604);
        first_source <= 1'b0;
        oc(1'b0);
        chk(pad_level, 1'b0, "falling edge load");
        wb(1'b0, 8'h04, '0, r);
        chk(r, 32'h0000_0010, "status word");
        wb(1'b1, 8'h08, 32'h0000_0001, r);
        w(3);
        chk(pad_level, 1'b1, "pulse preset");
        wrap_up;
    end
endmodule
